// File: hw/ipd_decoder.sv
// Behaviour
// R01 - Both inputs of a command share one connector
// R02 - Second input inherits connector of the first
// R03 - Letters L H F R select low/high/fall/rise
// R04 - Single-bank drives accept and ignore prefix
// R05 - Basic map: index, digital, command, two analogs
// R06 - Number zero is index, only with encoder
// R07 - Expansion: prefix main board, none top board
// R08 - Top board accepts digital inputs one to eight
// R09 - Reduced map: index, inputs one-four, analog eight
// R10 - Reduced dual: prefix 15-pin, none option connector
// R11 - Edges from sample compare, one-cycle pulse
// R12 - Current flowing reads low, none reads high
// R13 - Analog low below threshold, high above
module ipd_decoder (
  // Clock, reset and enable
  input wire logic clock,
  input wire logic resetn,
  input wire logic clk_en,
  // Command characters from the host parser
  input wire logic char_valid,
  input wire logic [7:0] char_data,
  input wire logic cmd_start,
  // Drive configuration
  input wire ipd_pkg::ipd_cfg_t cfg,
  input wire logic encoder_fitted,
  // Drive inputs
  input wire logic encoder_index,
  input wire logic [ipd_pkg::DIG_W-1:0] main_current,
  input wire logic [ipd_pkg::DIG_W-1:0] top_current,
  input wire logic [ipd_pkg::ADC_W-1:0] analog_command,
  input wire logic [ipd_pkg::ADC_W-1:0] analog_input_one,
  input wire logic [ipd_pkg::ADC_W-1:0] analog_input_two,
  input wire logic [ipd_pkg::ADC_W-1:0] single_analog_input,
  input wire logic [ipd_pkg::ADC_W-1:0] analog_threshold_setting,
  // Decoded selections and evaluation
  output ipd_pkg::ipd_sel_t sel_first,
  output ipd_pkg::ipd_sel_t sel_second,
  output logic param_done,
  output logic param_error,
  output logic [1:0] cond_met
);

  // Map an input number to a source for the given configuration and bank
  function automatic ipd_pkg::ipd_num_t decode_num(input ipd_pkg::ipd_cfg_t c,
      input logic main_bank, input logic enc_ok, input logic [7:0] num);
    ipd_pkg::ipd_num_t r;
    logic top;
    logic red;
    r = '0;
    top = !main_bank && (c == ipd_pkg::cfg_expansion || c == ipd_pkg::cfg_reduced_dual);
    red = (c == ipd_pkg::cfg_reduced) || (c == ipd_pkg::cfg_reduced_dual);
    if (top) begin // R07 R08 R10
      r.ok = (num >= ipd_pkg::NUM_DIG_FIRST) && (num <= ipd_pkg::NUM_TOP_LAST);
      r.src = ipd_pkg::SRC_TOP_BASE + num[ipd_pkg::SRC_W-1:0];
    end else if (num == ipd_pkg::NUM_ENC) begin // R06
      r.ok = enc_ok;
      r.src = ipd_pkg::SRC_ENC;
    end else if (red) begin // R09 R10
      if (num >= ipd_pkg::NUM_DIG_FIRST && num <= ipd_pkg::NUM_RED_LAST) begin
        r.ok = 1'b1;
        r.src = ipd_pkg::SRC_MAIN_BASE + num[ipd_pkg::SRC_W-1:0];
      end else if (num == ipd_pkg::NUM_SINGLE_AIN) begin
        r.ok = 1'b1;
        r.src = ipd_pkg::SRC_SINGLE_AIN;
      end
    end else begin // R05
      if (num >= ipd_pkg::NUM_DIG_FIRST && num <= ipd_pkg::NUM_BASIC_LAST) begin
        r.ok = 1'b1;
        r.src = ipd_pkg::SRC_MAIN_BASE + num[ipd_pkg::SRC_W-1:0];
      end else if (num == ipd_pkg::NUM_ANA_CMD) begin
        r.ok = 1'b1;
        r.src = ipd_pkg::SRC_ANA_CMD;
      end else if (num == ipd_pkg::NUM_AIN_ONE) begin
        r.ok = 1'b1;
        r.src = ipd_pkg::SRC_AIN_ONE;
      end else if (num == ipd_pkg::NUM_AIN_TWO) begin
        r.ok = 1'b1;
        r.src = ipd_pkg::SRC_AIN_TWO;
      end
    end
    return r;
  endfunction

  // Evaluate a condition against the current and previous samples
  function automatic logic cond_eval(input ipd_pkg::ipd_cond_t c, input logic hi,
      input logic lo, input logic was_hi);
    logic r;
    r = 1'b0;
    case (c)
      ipd_pkg::cond_low: r = lo;
      ipd_pkg::cond_high: r = hi;
      ipd_pkg::cond_fall: r = was_hi & ~hi; // R11
      default: r = hi & ~was_hi; // R11
    endcase
    return r;
  endfunction

  ipd_pkg::ipd_state_t state;
  logic pidx;
  logic prefix_seen;
  logic bank_first;
  logic [ipd_pkg::SRC_W-1:0] num_src;
  logic [ipd_pkg::NUM_SRC-1:0] hi_q;
  logic [ipd_pkg::NUM_SRC-1:0] lo_q;
  logic [ipd_pkg::NUM_SRC-1:0] hi_prev;

  // Raw levels of every source
  wire logic [ipd_pkg::NUM_SRC-1:0] hi_now;
  wire logic [ipd_pkg::NUM_SRC-1:0] lo_now;
  wire logic ana_cmd_hi = analog_command > analog_threshold_setting; // R13
  wire logic analog_input_one_hi = analog_input_one > analog_threshold_setting;
  wire logic analog_input_two_hi = analog_input_two > analog_threshold_setting;
  wire logic sain_hi = single_analog_input > analog_threshold_setting;
  wire logic ana_cmd_lo = analog_command < analog_threshold_setting; // R13
  wire logic analog_input_one_lo = analog_input_one < analog_threshold_setting;
  wire logic analog_input_two_lo = analog_input_two < analog_threshold_setting;
  wire logic sain_lo = single_analog_input < analog_threshold_setting;
  assign hi_now = {~top_current, sain_hi, analog_input_two_hi, analog_input_one_hi, ana_cmd_hi,
                   ~main_current, encoder_index}; // R12
  assign lo_now = {top_current, sain_lo, analog_input_two_lo, analog_input_one_lo, ana_cmd_lo,
                   main_current, ~encoder_index}; // R12

  // Character classification
  wire logic take = clk_en && char_valid;
  wire ipd_pkg::ipd_state_t cur_state = cmd_start ? ipd_pkg::st_number : state;
  wire logic cur_pidx = cmd_start ? 1'b0 : pidx;
  wire logic cur_prefix = cmd_start ? 1'b0 : prefix_seen;
  wire logic [7:0] num_val = char_data - ipd_pkg::CH_ZERO;
  wire logic is_num = char_data >= ipd_pkg::CH_ZERO && char_data <= ipd_pkg::CH_COLON;
  wire logic is_prefix = char_data == ipd_pkg::CH_PREFIX;
  wire logic main_bank = cur_pidx ? bank_first : cur_prefix; // R01 R02 R04
  wire ipd_pkg::ipd_num_t dec = decode_num(cfg, main_bank, encoder_fitted, num_val);
  wire logic is_low = char_data == ipd_pkg::CH_LOW;
  wire logic is_high = char_data == ipd_pkg::CH_HIGH;
  wire logic is_fall = char_data == ipd_pkg::CH_FALL;
  wire logic is_rise = char_data == ipd_pkg::CH_RISE;
  wire logic let_ok = is_low || is_high || is_fall || is_rise;
  wire ipd_pkg::ipd_cond_t let_cond = is_low ? ipd_pkg::cond_low :
                                      is_high ? ipd_pkg::cond_high :
                                      is_fall ? ipd_pkg::cond_fall :
                                      ipd_pkg::cond_rise; // R03

  // Parser step decisions
  wire logic in_num = take && cur_state == ipd_pkg::st_number;
  wire logic in_cond = take && cur_state == ipd_pkg::st_condition;
  wire logic got_prefix = in_num && is_prefix && !cur_prefix;
  wire logic got_num = in_num && is_num && dec.ok;
  wire logic got_cond = in_cond && let_ok;
  wire logic bad_char = (in_num && !got_prefix && !got_num) || (in_cond && !let_ok);
  wire ipd_pkg::ipd_sel_t new_sel = '{valid: 1'b1, src: num_src, cond: let_cond};

  // Next values of the parser
  wire ipd_pkg::ipd_state_t next_state = got_num ? ipd_pkg::st_condition :
                                         (got_cond || bad_char) ? ipd_pkg::st_number :
                                         cur_state;
  wire logic next_pidx = got_cond ? 1'b1 : cur_pidx;
  wire logic next_prefix = got_prefix ? 1'b1 : ((got_cond || bad_char) ? 1'b0 : cur_prefix);
  wire logic next_bank_first = (got_num && !cur_pidx) ? main_bank : bank_first; // R02
  wire ipd_pkg::ipd_sel_t next_first = (got_cond && !cur_pidx) ? new_sel :
                                       (take && cmd_start) ? '0 : sel_first;
  wire ipd_pkg::ipd_sel_t next_second = (got_cond && cur_pidx) ? new_sel :
                                        (take && cmd_start) ? '0 : sel_second;
  wire logic [1:0] next_met = {
    sel_second.valid && cond_eval(sel_second.cond, hi_q[sel_second.src],
                                  lo_q[sel_second.src], hi_prev[sel_second.src]),
    sel_first.valid && cond_eval(sel_first.cond, hi_q[sel_first.src],
                                 lo_q[sel_first.src], hi_prev[sel_first.src])};

  // Parser registers
  always_ff @(posedge clock) begin
    if (!resetn) begin
      state <= ipd_pkg::st_number;
      pidx <= 1'b0;
      prefix_seen <= 1'b0;
      bank_first <= 1'b0;
      num_src <= '0;
    end else if (take) begin
      state <= next_state;
      pidx <= next_pidx;
      prefix_seen <= next_prefix;
      bank_first <= next_bank_first;
      num_src <= got_num ? dec.src : num_src;
    end
  end

  // Output registers
  always_ff @(posedge clock) begin
    if (!resetn) begin
      sel_first <= '0;
      sel_second <= '0;
      param_done <= 1'b0;
      param_error <= 1'b0;
      cond_met <= '0;
    end else if (clk_en) begin
      sel_first <= next_first;
      sel_second <= next_second;
      param_done <= got_cond;
      param_error <= bad_char;
      cond_met <= next_met;
    end
  end

  // Input samples and previous samples for edge detection
  always_ff @(posedge clock) begin
    if (!resetn) begin
      hi_q <= '0;
      lo_q <= '0;
      hi_prev <= '0;
    end else if (clk_en) begin
      hi_q <= hi_now;
      lo_q <= lo_now;
      hi_prev <= hi_q; // R11
    end
  end

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  chk_letter_fall: assert property ( // R03
    got_cond && is_fall |=> param_done &&
      (sel_first.cond == ipd_pkg::cond_fall || sel_second.cond == ipd_pkg::cond_fall))
    else $error("falling letter not decoded as falling edge");
  chk_prefix_ignored: assert property ( // R04
    (cfg == ipd_pkg::cfg_basic || cfg == ipd_pkg::cfg_reduced) |->
      decode_num(cfg, 1'b1, encoder_fitted, num_val) ==
      decode_num(cfg, 1'b0, encoder_fitted, num_val))
    else $error("prefix changed decoding on a single-bank drive");
  chk_second_bank: assert property ( // R02
    got_cond && cur_pidx && cfg == ipd_pkg::cfg_expansion && bank_first
      |=> sel_second.src <= ipd_pkg::SRC_AIN_TWO)
    else $error("second input left the first input's connector");
  chk_encoder_gate: assert property ( // R06
    in_num && is_num && num_val == ipd_pkg::NUM_ENC && main_bank && !encoder_fitted
      |=> param_error)
    else $error("index accepted without an encoder");
  chk_top_range: assert property ( // R08
    sel_first.valid && sel_first.src > ipd_pkg::SRC_SINGLE_AIN |->
      (cfg == ipd_pkg::cfg_expansion || cfg == ipd_pkg::cfg_reduced_dual))
    else $error("top connector input outside a two-connector drive");
  chk_reduced_map: assert property ( // R09
    cfg == ipd_pkg::cfg_reduced && sel_first.valid |->
      (sel_first.src <= ipd_pkg::NUM_RED_LAST[ipd_pkg::SRC_W-1:0] ||
       sel_first.src == ipd_pkg::SRC_SINGLE_AIN))
    else $error("reduced drive selected an absent input");
  chk_edge_pulse: assert property ( // R11
    clk_en && cond_met[0] && sel_first.cond == ipd_pkg::cond_rise && $stable(sel_first)
      |=> !cond_met[0])
    else $error("rising edge reported longer than one cycle");
  chk_digital_low: assert property ( // R12
    clk_en && sel_first.valid && sel_first.cond == ipd_pkg::cond_low &&
      sel_first.src == ipd_pkg::SRC_MAIN_BASE + 5'h01 && main_current[0]
      ##1 clk_en && $stable(sel_first) |=> cond_met[0])
    else $error("current-carrying input did not read low");
  chk_analog_high: assert property ( // R13
    clk_en && sel_first.valid && sel_first.cond == ipd_pkg::cond_high &&
      sel_first.src == ipd_pkg::SRC_AIN_ONE && analog_input_one_hi
      ##1 clk_en && $stable(sel_first) |=> cond_met[0])
    else $error("analog above threshold did not read high");

  cov_rise_seen: cover property (sel_first.cond == ipd_pkg::cond_rise && cond_met[0]);
  cov_two_params: cover property (param_done && sel_second.valid);
  cov_bad_char: cover property (param_error);

endmodule

// File: hw/ipd_pkg.sv
package ipd_pkg;

  // Drive configuration: which connector map the decoder applies
  typedef enum logic [1:0] {
    cfg_basic,
    cfg_expansion,
    cfg_reduced,
    cfg_reduced_dual
  } ipd_cfg_t;

  // Input condition named by the trailing letter
  typedef enum logic [1:0] {
    cond_low,
    cond_high,
    cond_fall,
    cond_rise
  } ipd_cond_t;

  // Parser position within one input parameter
  typedef enum logic {
    st_number,
    st_condition
  } ipd_state_t;

  // Widths
  localparam int unsigned ADC_W = 12;
  localparam int unsigned SRC_W = 5;
  localparam int unsigned NUM_SRC = 21;
  localparam int unsigned DIG_W = 8;

  // Command characters
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_COLON = 8'h3a;
  localparam logic [7:0] CH_PREFIX = 8'h58;
  localparam logic [7:0] CH_LOW = 8'h4c;
  localparam logic [7:0] CH_HIGH = 8'h48;
  localparam logic [7:0] CH_FALL = 8'h46;
  localparam logic [7:0] CH_RISE = 8'h52;

  // Input numbers after the character offset is removed
  localparam logic [7:0] NUM_ENC = 8'h00;
  localparam logic [7:0] NUM_DIG_FIRST = 8'h01;
  localparam logic [7:0] NUM_BASIC_LAST = 8'h07;
  localparam logic [7:0] NUM_RED_LAST = 8'h04;
  localparam logic [7:0] NUM_TOP_LAST = 8'h08;
  localparam logic [7:0] NUM_ANA_CMD = 8'h08;
  localparam logic [7:0] NUM_AIN_ONE = 8'h09;
  localparam logic [7:0] NUM_AIN_TWO = 8'h0a;
  localparam logic [7:0] NUM_SINGLE_AIN = 8'h08;

  // Positions in the internal source vector
  localparam logic [SRC_W-1:0] SRC_ENC = 5'h00;
  localparam logic [SRC_W-1:0] SRC_MAIN_BASE = 5'h00;
  localparam logic [SRC_W-1:0] SRC_ANA_CMD = 5'h09;
  localparam logic [SRC_W-1:0] SRC_AIN_ONE = 5'h0a;
  localparam logic [SRC_W-1:0] SRC_AIN_TWO = 5'h0b;
  localparam logic [SRC_W-1:0] SRC_SINGLE_AIN = 5'h0c;
  localparam logic [SRC_W-1:0] SRC_TOP_BASE = 5'h0c;

  // One decoded input parameter
  typedef struct packed {
    logic valid;
    logic [SRC_W-1:0] src;
    ipd_cond_t cond;
  } ipd_sel_t;

  // Result of decoding an input number
  typedef struct packed {
    logic ok;
    logic [SRC_W-1:0] src;
  } ipd_num_t;

endpackage

// File: tb/ipd_host.sv
module ipd_host (
  // Clock
  input wire logic clock,
  // Character stream towards the decoder
  output logic char_valid,
  output logic [7:0] char_data,
  output logic cmd_start
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle at time zero
  initial begin
    char_valid = 1'b0;
    char_data = 8'h00;
    cmd_start = 1'b0;
  end

  // Sends one parameter, one character per cycle; command start is only flagged on the first character of the first one
  task automatic send(input string s, input logic first);
    for (int i = 0; i < s.len(); i++) begin
      @(posedge clock);
      #1;
      char_valid = 1'b1;
      char_data = s[i];
      cmd_start = first && (i == 0);
    end
    @(posedge clock);
    #1;
    char_valid = 1'b0;
    cmd_start = 1'b0;
    char_data = ~char_data; // Released data must not keep its last value
  endtask
endmodule

// File: tb/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct {
    ipd_pkg::ipd_cfg_t cfg;
    logic enc;
    string s;
    logic err;
    logic [4:0] src;
    ipd_pkg::ipd_cond_t cond;
  } ipd_row_t;

  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic clk_en = 1'b1;
  logic char_valid;
  logic [7:0] char_data;
  logic cmd_start;
  ipd_pkg::ipd_cfg_t cfg = ipd_pkg::cfg_basic;
  logic encoder_fitted = 1'b1;
  logic encoder_index = 1'b0;
  logic [7:0] main_current = 8'h00;
  logic [7:0] top_current = 8'h00;
  logic [11:0] analog_command = 12'h000;
  logic [11:0] analog_input_one = 12'h000;
  logic [11:0] analog_input_two = 12'h000;
  logic [11:0] single_analog_input = 12'h000;
  logic [11:0] analog_threshold_setting = 12'h064;
  ipd_pkg::ipd_sel_t sel_first;
  ipd_pkg::ipd_sel_t sel_second;
  ipd_pkg::ipd_sel_t exp_sel;
  logic param_done;
  logic param_error;
  logic [1:0] cond_met;
  int mismatches = 0;
  int n_checks = 0;

  // Single parameters: configuration, text, refused, expected source and condition
  ipd_row_t rows [18] = '{
    '{ipd_pkg::cfg_basic, 1'b1, "X3R", 1'b0, 5'h03, ipd_pkg::cond_rise},
    '{ipd_pkg::cfg_basic, 1'b1, "0L", 1'b0, 5'h00, ipd_pkg::cond_low},
    '{ipd_pkg::cfg_basic, 1'b0, "0", 1'b1, 5'h00, ipd_pkg::cond_low},
    '{ipd_pkg::cfg_basic, 1'b1, "7H", 1'b0, 5'h07, ipd_pkg::cond_high},
    '{ipd_pkg::cfg_basic, 1'b1, "8F", 1'b0, 5'h09, ipd_pkg::cond_fall},
    '{ipd_pkg::cfg_basic, 1'b1, "9L", 1'b0, 5'h0a, ipd_pkg::cond_low},
    '{ipd_pkg::cfg_basic, 1'b1, ":H", 1'b0, 5'h0b, ipd_pkg::cond_high},
    '{ipd_pkg::cfg_basic, 1'b1, "3Q", 1'b1, 5'h00, ipd_pkg::cond_low},
    '{ipd_pkg::cfg_expansion, 1'b1, "X:L", 1'b0, 5'h0b, ipd_pkg::cond_low},
    '{ipd_pkg::cfg_expansion, 1'b1, "8R", 1'b0, 5'h14, ipd_pkg::cond_rise},
    '{ipd_pkg::cfg_expansion, 1'b1, "1F", 1'b0, 5'h0d, ipd_pkg::cond_fall},
    '{ipd_pkg::cfg_expansion, 1'b1, "9", 1'b1, 5'h00, ipd_pkg::cond_low},
    '{ipd_pkg::cfg_reduced, 1'b1, "X4L", 1'b0, 5'h04, ipd_pkg::cond_low},
    '{ipd_pkg::cfg_reduced, 1'b1, "8H", 1'b0, 5'h0c, ipd_pkg::cond_high},
    '{ipd_pkg::cfg_reduced, 1'b1, "5", 1'b1, 5'h00, ipd_pkg::cond_low},
    '{ipd_pkg::cfg_reduced_dual, 1'b1, "X8F", 1'b0, 5'h0c, ipd_pkg::cond_fall},
    '{ipd_pkg::cfg_reduced_dual, 1'b1, "8R", 1'b0, 5'h14, ipd_pkg::cond_rise},
    '{ipd_pkg::cfg_reduced_dual, 1'b1, "X5", 1'b1, 5'h00, ipd_pkg::cond_low}
  };

  // 100 MHz clock
  always #5 clock = ~clock;

  ipd_host ipd_host_inst (
    .clock(clock),
    .char_valid(char_valid),
    .char_data(char_data),
    .cmd_start(cmd_start)
  );

  ipd_decoder ipd_decoder_inst (
    .clock(clock), .resetn(resetn), .clk_en(clk_en),
    .char_valid(char_valid), .char_data(char_data), .cmd_start(cmd_start),
    .cfg(cfg), .encoder_fitted(encoder_fitted), .encoder_index(encoder_index),
    .main_current(main_current), .top_current(top_current),
    .analog_command(analog_command), .analog_input_one(analog_input_one),
    .analog_input_two(analog_input_two), .single_analog_input(single_analog_input),
    .analog_threshold_setting(analog_threshold_setting),
    .sel_first(sel_first), .sel_second(sel_second),
    .param_done(param_done), .param_error(param_error), .cond_met(cond_met)
  );

  // Counts one comparison and reports a mismatch
  task automatic check(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask

  // Sends a parameter and checks the one-cycle pulse while it still stands
  task automatic param(input string s, input logic first, input logic err);
    ipd_host_inst.send(s, first);
    check(param_done === !err && param_error === err, {"pulse after ", s});
  endtask

  // Waits two edges for the evaluation and checks it
  task automatic eval_check(input logic [1:0] exp, input string msg);
    repeat (2) @(posedge clock);
    #1;
    check(cond_met === exp, msg);
  endtask

  task automatic stop_test;
    if (mismatches == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Watchdog
  initial begin
    #200us;
    mismatches++;
    stop_test();
  end

  initial begin
    repeat (12) @(posedge clock);
    #1;
    check({sel_first, sel_second, param_done, param_error, cond_met} === 20'h00000, "reset");
    resetn = 1'b1;
    // Table of single parameters
    foreach (rows[i]) begin
      cfg = rows[i].cfg;
      encoder_fitted = rows[i].enc;
      param(rows[i].s, 1'b1, rows[i].err);
      exp_sel = '{valid: 1'b1, src: rows[i].src, cond: rows[i].cond};
      if (!rows[i].err) check(sel_first === exp_sel, {"selection ", rows[i].s});
    end
    // Second input follows the bank of the first, with or without a prefix
    cfg = ipd_pkg::cfg_expansion;
    param("X3R", 1'b1, 1'b0);
    param("5L", 1'b0, 1'b0);
    check(sel_second === ipd_pkg::ipd_sel_t'({1'b1, 5'h05, ipd_pkg::cond_low}), "bank");
    param("X6H", 1'b0, 1'b0);
    check(sel_second === ipd_pkg::ipd_sel_t'({1'b1, 5'h06, ipd_pkg::cond_high}), "pre");
    // Current flowing reads low and gives a one-cycle falling edge
    cfg = ipd_pkg::cfg_basic;
    param("X1L", 1'b1, 1'b0);
    param("1F", 1'b0, 1'b0);
    eval_check(2'b00, "open input");
    main_current = 8'h01;
    eval_check(2'b11, "closed input");
    @(posedge clock);
    #1;
    check(cond_met === 2'b01, "edge pulse length");
    // Analog low below the threshold, not low when equal
    analog_input_one = 12'h063;
    param("9L", 1'b1, 1'b0);
    eval_check(2'b01, "analog below");
    analog_input_one = 12'h064;
    eval_check(2'b00, "analog equal");
    // A low enable freezes the samples and the evaluation
    clk_en = 1'b0;
    analog_input_one = 12'h063;
    eval_check(2'b00, "frozen by enable");
    clk_en = 1'b1;
    eval_check(2'b01, "enable restored");
    stop_test();
  end
endmodule
